// File: core/tape_channel.sv
/*
 * tape recorder serial channel: bus decode, tape mode, transmitter,
 * receive holding, i/o done and interrupt registers.
 * assumes bus pins are asynchronous and are synchronised here.
 */
module tape_channel #(
    parameter int BIT_CYCLES = tape_pkg::BIT_CYCLES
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // processor i/o bus
    input wire logic [15:0] MAIN_ADDR_N,
    input wire logic ADDR0_SELECT_N,
    input wire logic IO_READ_STROBE_N,
    input wire logic IO_WRITE_STROBE_N,
    input wire logic [15:0] MD_IN,
    output logic [15:0] MD_OUT,
    output logic MD_OE_N,
    output logic IO_DONE_N,
    output logic CHAN5_ENABLE_N,
    // tape link
    input wire logic SERIAL_RX_LINE,
    input wire logic TAPE_REPLY_LINE,
    output logic SERIAL_TX_LINE,
    output logic SET_READY_LINE,
    output logic CHAN_WRITE_LINE,
    // flags
    output logic RX_WORD_READY,
    output logic TX_BUF_EMPTY,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic IRQ
);
    localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);

    // pin synchroniser, first stage read only by the second
    logic [36:0] sync1_q, sync2_q;
    logic [15:0] s_addr_n, s_md;
    logic s_a0n, s_rd_n, s_wr_n, s_rxl, s_reply;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sync1_q <= tape_pkg::SYNC_RST;
            sync2_q <= tape_pkg::SYNC_RST;
        end else begin
            sync1_q <= {MAIN_ADDR_N, ADDR0_SELECT_N, IO_READ_STROBE_N,
                        IO_WRITE_STROBE_N, MD_IN, SERIAL_RX_LINE,
                        TAPE_REPLY_LINE};
            sync2_q <= sync1_q;
        end
    end

    assign {s_addr_n, s_a0n, s_rd_n, s_wr_n, s_md, s_rxl, s_reply} =
        sync2_q;

    // address decode
    logic [15:0] addr;
    logic [7:0] key;
    logic hit_cmd, hit_data, hit_ch5, a0_low, sel_cmd, sel_data;
    logic rd_act, wr_act, rd_prev_q, wr_prev_q, rd_go, wr_go;

    assign addr = ~s_addr_n;
    assign key = {addr[15], addr[10:4]};
    assign hit_cmd = key == tape_pkg::SEL_CMD_PAT;
    assign hit_data = key == tape_pkg::SEL_DATA_PAT;
    assign hit_ch5 = key == tape_pkg::CHAN5_PAT;
    assign a0_low = !s_a0n;
    assign sel_cmd = (hit_cmd || hit_ch5) && a0_low;
    assign sel_data = (hit_data || hit_ch5) && !a0_low;
    assign rd_act = !s_rd_n;
    assign wr_act = !s_wr_n;
    // strobes are levels; act once on their leading edge
    assign rd_go = rd_act && !rd_prev_q;
    assign wr_go = wr_act && !wr_prev_q;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
            CHAN5_ENABLE_N <= 1'b1;
        end else begin
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
            CHAN5_ENABLE_N <= !hit_ch5;
        end
    end

    // tape mode: steers the in/out multiplexer
    logic tape_mode_q;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            tape_mode_q <= 1'b0;
        end else if (wr_go && sel_cmd) begin
            tape_mode_q <= s_md[tape_pkg::MODE_BIT];
        end
    end

    assign SET_READY_LINE = tape_mode_q;
    assign CHAN_WRITE_LINE = tape_mode_q;

    // i/o done follows the strobe while this interface is addressed
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            IO_DONE_N <= 1'b1;
        end else begin
            IO_DONE_N <= !((rd_act || wr_act)
                           && (sel_cmd || sel_data));
        end
    end

    // receiver and holding register
    rx_link_if lnk ();
    logic [7:0] rx_word_q;
    logic rx_ready_q;
    // tape replies arrive on their own lead in tape mode
    assign lnk.line = tape_mode_q ? s_reply : s_rxl;

    tape_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .clk(REF_CLK),
        .rst(RESET),
        .lnk(lnk.rx)
    );

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rx_word_q <= 8'h00;
            rx_ready_q <= 1'b0;
        end else if (lnk.valid) begin
            // a new word wins over a read in the same cycle
            rx_word_q <= lnk.word;
            rx_ready_q <= 1'b1;
        end else if (rd_go && sel_data) begin
            rx_ready_q <= 1'b0;
        end
    end

    assign RX_WORD_READY = rx_ready_q;

    // read data back onto the bus
    logic [7:0] status;
    assign status = {5'h00, tape_mode_q, TX_BUF_EMPTY, rx_ready_q};

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            MD_OUT <= 16'h0000;
            MD_OE_N <= 1'b1;
        end else begin
            MD_OE_N <= !(rd_act && (sel_cmd || sel_data));
            if (rd_act && sel_data) begin
                MD_OUT <= {8'h00, rx_word_q};
            end else if (rd_act && sel_cmd) begin
                MD_OUT <= {8'h00, status};
            end
        end
    end

    // send buffer; a write while full is dropped and flagged
    logic [7:0] tx_buf_q;
    logic tx_empty_q, tx_load, tx_take;
    tape_pkg::ser_state_t tx_st_q;

    assign tx_load = wr_go && sel_data && tx_empty_q;
    assign tx_take = tx_st_q == tape_pkg::SER_IDLE && !tx_empty_q;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            tx_buf_q <= 8'h00;
            tx_empty_q <= 1'b1;
        end else if (tx_load) begin
            tx_buf_q <= s_md[7:0];
            tx_empty_q <= 1'b0;
        end else if (tx_take) begin
            tx_empty_q <= 1'b1;
        end
    end

    assign TX_BUF_EMPTY = tx_empty_q;

    // baud divider restarts with each frame so the start bit lasts a full bit time
    logic [15:0] baud_q;
    logic tick;
    assign tick = baud_q == 16'h0000
                  && tx_st_q != tape_pkg::SER_IDLE;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            baud_q <= 16'h0000;
        end else if (tx_take || baud_q == 16'h0000) begin
            baud_q <= FULL;
        end else begin
            baud_q <= baud_q - 16'h0001;
        end
    end

    // transmitter
    logic [7:0] tx_sh_q;
    logic [2:0] tx_bit_q;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            tx_st_q <= tape_pkg::SER_IDLE;
            tx_sh_q <= 8'h00;
            tx_bit_q <= 3'h0;
            SERIAL_TX_LINE <= 1'b1;
        end else begin
            unique case (tx_st_q)
                tape_pkg::SER_IDLE: begin
                    if (tx_take) begin
                        tx_sh_q <= tx_buf_q;
                        SERIAL_TX_LINE <= 1'b0;
                        tx_st_q <= tape_pkg::SER_START;
                    end
                end
                tape_pkg::SER_START: begin
                    if (tick) begin
                        SERIAL_TX_LINE <= tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= 3'h0;
                        tx_st_q <= tape_pkg::SER_DATA;
                    end
                end
                tape_pkg::SER_DATA: begin
                    if (tick && tx_bit_q == 3'h7) begin
                        SERIAL_TX_LINE <= 1'b1;
                        tx_st_q <= tape_pkg::SER_STOP;
                    end else if (tick) begin
                        SERIAL_TX_LINE <= tx_sh_q[0];
                        tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                    end
                end
                tape_pkg::SER_STOP: begin
                    if (tick) begin
                        tx_st_q <= tape_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt status and mask
    logic [3:0] sts_q, mask_q, ev, clr;

    assign ev[tape_pkg::EV_RX] = lnk.valid;
    assign ev[tape_pkg::EV_TX] = tx_take;
    assign ev[tape_pkg::EV_OVR] = (lnk.valid && rx_ready_q)
                                  || (wr_go && sel_data && !tx_empty_q);
    assign ev[tape_pkg::EV_FERR] = lnk.frame_err;
    assign clr = (REG_WR && REG_ADDR == tape_pkg::REG_STATUS)
                 ? REG_WDATA[3:0] : 4'h0;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sts_q <= 4'h0;
        end else begin
            // set wins over a clear in the same cycle
            sts_q <= (sts_q & ~clr) | ev;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            mask_q <= tape_pkg::MASK_RST;
        end else if (REG_WR && REG_ADDR == tape_pkg::REG_MASK) begin
            mask_q <= REG_WDATA[3:0];
        end
    end

    assign IRQ = |(sts_q & mask_q);

    always_ff @(posedge REF_CLK) begin
        if (RESET || !REG_RD) begin
            REG_RDATA <= 8'h00;
        end else begin
            unique case (REG_ADDR)
                tape_pkg::REG_STATUS: REG_RDATA <= {4'h0, sts_q};
                tape_pkg::REG_MASK: REG_RDATA <= {4'h0, mask_q};
                tape_pkg::REG_STATE: REG_RDATA <= status;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    property p_mode_cmd;
        (wr_go && hit_cmd && a0_low)
            |=> tape_mode_q == $past(s_md[tape_pkg::MODE_BIT]);
    endproperty
    a_mode_cmd: assert property (p_mode_cmd)
        else $error("command access did not set tape mode");
    property p_chan5_mode;
        (wr_go && hit_ch5 && a0_low && s_md[tape_pkg::MODE_BIT])
            |=> SET_READY_LINE && CHAN_WRITE_LINE;
    endproperty
    a_chan5_mode: assert property (p_chan5_mode)
        else $error("tape mode lines not raised");
    property p_data_load;
        (wr_go && hit_data && !a0_low && tx_empty_q)
            |=> !tx_empty_q && tx_buf_q == $past(s_md[7:0]);
    endproperty
    a_data_load: assert property (p_data_load)
        else $error("data write not loaded");
    property p_cmd_noload;
        (wr_go && a0_low && !tx_take) |=> $stable(tx_empty_q);
    endproperty
    a_cmd_noload: assert property (p_cmd_noload)
        else $error("command access touched send buffer");
    property p_done;
        ((rd_act || wr_act) && (sel_cmd || sel_data)) |=> !IO_DONE_N;
    endproperty
    a_done: assert property (p_done)
        else $error("i/o done missing");
    property p_rx_flag;
        lnk.valid |=> RX_WORD_READY && rx_word_q == $past(lnk.word);
    endproperty
    a_rx_flag: assert property (p_rx_flag)
        else $error("received word not flagged");
    property p_tx_start;
        tx_take |=> TX_BUF_EMPTY ##0 !SERIAL_TX_LINE [*8];
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("start bit not sent");
    property p_tx_empty;
        (tx_st_q == tape_pkg::SER_IDLE && !tx_empty_q) |=> TX_BUF_EMPTY;
    endproperty
    a_tx_empty: assert property (p_tx_empty)
        else $error("send buffer not freed by idle transmitter");
    property p_baud;
        tick |=> baud_q == FULL;
    endproperty
    a_baud: assert property (p_baud)
        else $error("baud divider not reloaded");
    property p_oe;
        !MD_OE_N |-> $past(rd_act);
    endproperty
    a_oe: assert property (p_oe)
        else $error("bus driven without read strobe");
endmodule // tape_channel

// File: core/tape_rx.sv
/*
 * serial-to-parallel receiver, 8N1, sampling at bit centre.
 * assumes a synchronised line and a synchronous active-high reset.
 */
module tape_rx #(
    parameter int BIT_CYCLES = tape_pkg::BIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link to core
    rx_link_if.rx lnk
);
    localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

    tape_pkg::ser_state_t st_q;
    logic [15:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= tape_pkg::SER_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            lnk.word <= 8'h00;
            lnk.valid <= 1'b0;
            lnk.frame_err <= 1'b0;
        end else begin
            lnk.valid <= 1'b0;
            lnk.frame_err <= 1'b0;
            unique case (st_q)
                tape_pkg::SER_IDLE: begin
                    if (!lnk.line) begin
                        st_q <= tape_pkg::SER_START;
                        cnt_q <= HALF;
                    end
                end
                tape_pkg::SER_START: begin
                    if (cnt_q != 16'h0000) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else if (!lnk.line) begin
                        st_q <= tape_pkg::SER_DATA;
                        cnt_q <= FULL;
                        bit_q <= 3'h0;
                    end else begin
                        // glitch, not a start bit
                        st_q <= tape_pkg::SER_IDLE;
                    end
                end
                tape_pkg::SER_DATA: begin
                    if (cnt_q != 16'h0000) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else begin
                        sh_q <= {lnk.line, sh_q[7:1]};
                        cnt_q <= FULL;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_q <= tape_pkg::SER_STOP;
                        end
                    end
                end
                tape_pkg::SER_STOP: begin
                    if (cnt_q != 16'h0000) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else begin
                        lnk.word <= sh_q;
                        lnk.valid <= 1'b1;
                        lnk.frame_err <= !lnk.line;
                        st_q <= tape_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    property p_rx_centre;
        @(posedge clk) disable iff (rst)
        (st_q == tape_pkg::SER_IDLE && !lnk.line) |=> cnt_q == HALF;
    endproperty
    a_rx_centre: assert property (p_rx_centre)
        else $error("start bit not timed to centre");

    property p_rx_word;
        @(posedge clk) disable iff (rst)
        lnk.valid |-> $past(st_q) == tape_pkg::SER_STOP
            && lnk.word == $past(sh_q);
    endproperty
    a_rx_word: assert property (p_rx_word)
        else $error("word delivered outside stop bit");
endmodule // tape_rx

// File: shared/rx_link_if.sv
/*
 * link between the channel core and its serial receiver.
 * assumes line is already synchronised to the core clock.
 */
interface rx_link_if;
    logic line;
    logic [7:0] word;
    logic valid;
    logic frame_err;
    modport rx (input line, output word, valid, frame_err);
    modport core (output line, input word, valid, frame_err);
endinterface

// File: shared/tape_pkg.sv
/*
 * constants and types for the tape recorder serial channel.
 * assumes one 250 MHz clock and 8-bit words framed 8N1.
 */
package tape_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    localparam int WORD_BITS = 8;
    localparam int MODE_BIT = 11;
    localparam logic [7:0] SEL_CMD_PAT = 8'h6e;
    localparam logic [7:0] SEL_DATA_PAT = 8'h6f;
    localparam logic [7:0] CHAN5_PAT = 8'h8a;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_STATE = 4'h8;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [36:0] SYNC_RST = 37'h1fffffffff;
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_OVR = 2;
    localparam int EV_FERR = 3;
    localparam int ST_RX_READY = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_TAPE = 2;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_START = 2'b01,
        SER_DATA = 2'b10,
        SER_STOP = 2'b11
    } ser_state_t;
endpackage

// File: tb/tape_recorder_serial_channel_tb.sv
/*
 * self-checking bench for the tape channel: bus cycles, register port
 * and a far-end tape model on both receive lines.
 * assumes a short bit time of 16 clocks.
 */
module tape_recorder_serial_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 16;
    localparam logic [7:0] KC = tape_pkg::SEL_CMD_PAT;
    localparam logic [7:0] KD = tape_pkg::SEL_DATA_PAT;
    localparam logic [7:0] K5 = tape_pkg::CHAN5_PAT;
    logic ref_clk, reset, a0_n, rd_n, wr_n, reg_wr, reg_rd, rx_line;
    logic [15:0] addr_n, md_in, md_out;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic md_oe_n, done_n, c5_n, tx_line, rdy_line, cw_line, reply_line;
    logic rx_ready, tx_empty, irq;
    int mismatches = 0;
    int n_checks = 0;
    tape_channel #(.BIT_CYCLES(BC)) i_dut (
        .REF_CLK(ref_clk), .RESET(reset), .MAIN_ADDR_N(addr_n),
        .ADDR0_SELECT_N(a0_n), .IO_READ_STROBE_N(rd_n),
        .IO_WRITE_STROBE_N(wr_n), .MD_IN(md_in), .MD_OUT(md_out),
        .MD_OE_N(md_oe_n), .IO_DONE_N(done_n), .CHAN5_ENABLE_N(c5_n),
        .SERIAL_RX_LINE(rx_line), .TAPE_REPLY_LINE(reply_line),
        .SERIAL_TX_LINE(tx_line), .SET_READY_LINE(rdy_line),
        .CHAN_WRITE_LINE(cw_line), .RX_WORD_READY(rx_ready),
        .TX_BUF_EMPTY(tx_empty), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .IRQ(irq));
    // one model listens to the transmit line and answers in tape mode
    tape_unit_model #(.BIT_CYCLES(BC)) i_tape (
        .clk(ref_clk), .line_in(tx_line), .line_out(reply_line));
    tape_unit_model #(.BIT_CYCLES(BC)) i_term (
        .clk(ref_clk), .line_in(1'b1), .line_out(rx_line));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_rd_t(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    // key is {addr15, addr10..4}; pins carry the inverted address
    task automatic set_addr(input logic [7:0] key, input logic a0);
        @(posedge ref_clk);
        addr_n <= ~{key[7], 4'h0, key[6:0], 4'h0};
        a0_n <= a0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic bus(input logic [7:0] key, input logic a0,
                       input logic rd, input logic [15:0] wd,
                       input logic e_done, input logic [15:0] e_rd);
        @(posedge ref_clk);
        md_in <= wd;
        set_addr(key, a0);
        if (rd) rd_n <= 1'b0;
        else wr_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk("io_done_n", {15'h0, e_done}, {15'h0, done_n});
        if (rd) chk("md_out", e_rd, md_out);
        if (rd) chk("md_oe_n", 16'h0, {15'h0, md_oe_n});
        @(posedge ref_clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 chk("io_done_n idle", 16'h1, {15'h0, done_n});
    endtask
    task automatic wait_rx();
        int i;
        for (i = 0; i < 400 && rx_ready !== 1'b1; i++) @(posedge ref_clk);
        #1 chk("rx_word_ready", 16'h1, {15'h0, rx_ready});
    endtask
    initial begin
        #80us;
        mismatches++;
        end_sim();
    end
    initial begin
        int i;
        reset = 1'b1;
        addr_n = 16'hffff;
        a0_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        md_in = 16'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        reg_rd_t(tape_pkg::REG_STATUS, 8'h00);
        reg_rd_t(tape_pkg::REG_MASK, tape_pkg::MASK_RST);
        reg_rd_t(4'hc, 8'h00);
        chk("tx idle", 16'h1, {15'h0, tx_line});
        chk("tx empty", 16'h1, {15'h0, tx_empty});
        chk("irq", 16'h0, {15'h0, irq});
        reg_wr_t(tape_pkg::REG_MASK, 8'h05);
        reg_rd_t(tape_pkg::REG_MASK, 8'h05);
        set_addr(tape_pkg::CHAN5_PAT, 1'b0);
        #1 chk("chan5_enable_n", 16'h0, {15'h0, c5_n});
        bus(K5, 1'b0, 1'b0, 16'h0800, 1'b0, 16'h0);
        chk("set_ready", 16'h1, {15'h0, rdy_line});
        chk("chan_write", 16'h1, {15'h0, cw_line});
        bus(8'h00, 1'b0, 1'b0, 16'h0000, 1'b1, 16'h0);
        bus(KD, 1'b1, 1'b0, 16'h00a5, 1'b0, 16'h0);
        bus(KD, 1'b1, 1'b0, 16'h003c, 1'b0, 16'h0);
        bus(KD, 1'b1, 1'b0, 16'h00ff, 1'b0, 16'h0);
        reg_rd_t(tape_pkg::REG_STATUS, 8'h06);
        chk("irq ovr", 16'h1, {15'h0, irq});
        for (i = 0; i < 600 && i_tape.got_q.size() < 2; i++)
            @(posedge ref_clk);
        chk("words sent", 16'h2, 16'(i_tape.got_q.size()));
        chk("tx word0", 16'h00a5, {8'h0, i_tape.got_q[0]});
        chk("tx word1", 16'h003c, {8'h0, i_tape.got_q[1]});
        chk("tx empty again", 16'h1, {15'h0, tx_empty});
        reg_wr_t(tape_pkg::REG_STATUS, 8'h0f);
        #1 chk("irq cleared", 16'h0, {15'h0, irq});
        fork
            i_tape.send(8'h96);
            i_term.send(8'h11);
        join
        wait_rx();
        reg_rd_t(tape_pkg::REG_STATE, 8'h07);
        chk("irq rx", 16'h1, {15'h0, irq});
        bus(KC, 1'b0, 1'b1, 16'h0, 1'b0, 16'h0007);
        bus(KD, 1'b1, 1'b1, 16'h0, 1'b0, 16'h0096);
        chk("rx cleared", 16'h0, {15'h0, rx_ready});
        reg_wr_t(tape_pkg::REG_STATUS, 8'h01);
        #1 chk("irq w1c", 16'h0, {15'h0, irq});
        bus(KC, 1'b0, 1'b0, 16'h0000, 1'b0, 16'h0);
        chk("tape off", 16'h0, {15'h0, rdy_line});
        fork
            i_term.send(8'h5a);
            i_tape.send(8'h33);
        join
        wait_rx();
        bus(KD, 1'b1, 1'b1, 16'h0, 1'b0, 16'h005a);
        end_sim();
    end
endmodule // tape_recorder_serial_channel_tb

// File: tb/tape_unit_model.sv
/*
 * behavioural far-end tape unit: 8N1 serial sender and receiver.
 * assumes the core clock and a bit time of bit_cycles clocks.
 */
module tape_unit_model #(
    parameter int BIT_CYCLES = 16
) (
    // clock
    input wire logic clk,
    // serial pins
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    initial line_out = 1'b1;
    // commands and status travel as plain bytes; drive motion is not
    // modelled, so the unit only answers when the bench asks
    task automatic send(input logic [7:0] b);
        int i;
        @(posedge clk);
        line_out <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            line_out <= b[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
        line_out <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clk);
    endtask
    // receiver samples centre of each bit, lsb first
    initial begin
        logic [7:0] b;
        int i;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYCLES / 2) @(posedge clk);
            if (line_in === 1'b0) begin
                for (i = 0; i < 8; i++) begin
                    repeat (BIT_CYCLES) @(posedge clk);
                    b[i] = line_in;
                end
                repeat (BIT_CYCLES) @(posedge clk);
                if (line_in === 1'b1) got_q.push_back(b);
            end
        end
    end
endmodule // tape_unit_model
